// ==== verilog/sacs_pkg.sv ====
package sacs_pkg;
	// Resolution of the converted word
	localparam int RESOLUTION = 14;
	// Input sample width, wider than the code to show saturation
	localparam int SAMPLE_W = 16;
	// Internal cycles of self-calibration after power-up
	localparam int CAL_CYCLES = 64;
	// Conversion duration in ns and the cycle count from the clock rate
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CONV_TIME_NS = 600;
	localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int CNT_W = 16;

	typedef enum logic [1:0]
	{
		SACS_CALIBRATE = 2'b00,
		SACS_ACQUIRE = 2'b01,
		SACS_CONVERT = 2'b10
	} sacs_phase_t;

	// Saturate a signed sample to a two's complement code of width n
	function automatic logic [SAMPLE_W-1:0] sacs_saturate(
		input logic signed [SAMPLE_W-1:0] value,
		input int n
	);
		logic signed [SAMPLE_W-1:0] maxCode;
		logic signed [SAMPLE_W-1:0] minCode;
		maxCode = (SAMPLE_W'(1) <<< (n - 1)) - SAMPLE_W'(1);
		minCode = -(SAMPLE_W'(1) <<< (n - 1));
		if (value > maxCode)
			sacs_saturate = maxCode;
		else if (value < minCode)
			sacs_saturate = minCode;
		else
			sacs_saturate = value;
	endfunction
endpackage

// ==== verilog/sacs_edge_sync.sv ====
module sacs_edge_sync
	import sacs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic asyncIn,
	output logic level,
	output logic rise,
	output logic fall
);
	logic stage1;
	logic stage2;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			level <= 1'b0;
		end
		else
		begin
			stage1 <= asyncIn;
			stage2 <= stage1;
			level <= stage2;
		end
	end

	assign rise = stage2 & ~level;
	assign fall = ~stage2 & level;
endmodule

// ==== verilog/sacs_sequencer.sv ====
// Operation
// - After power-up, calibrate, then enter acquisition with no host command.
// - Track the input during acquisition until strobe rising edge.
// - Strobe rising edge freezes the sample and starts conversion.
// - Conversion runs to completion, fixed duration, ignores strobe.
// - Result appears only after conversion done and strobe low.
// - Shift result MSB first; first bit is the sign.
// - During shift-out the device is already acquiring again.
// - Sample period is acquisition window plus conversion duration.
// - Code equals differential input divided by one LSB.
// - Two's complement result, 14 or 12 bits; MSB gives sign.
// - Negative full scale 100..0, zero 0..0, positive full scale 011..1.
// - Saturate at 011..1 above range and 100..0 below.
// - SPI mode 0; device updates data on falling clock edges.
// - Output floats from start until strobe low, and after last bit.
module sacs_sequencer
	import sacs_pkg::*;
#(
	parameter int N_BITS = RESOLUTION,
	parameter int CAL_LEN = CAL_CYCLES,
	parameter int CONV_LEN = CONV_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic conversion_start_strobe,
	input wire logic serialClock,
	input wire logic signed [SAMPLE_W-1:0] inputLsb,
	output logic serialData,
	output logic serialData_oe_n,
	output logic tracking,
	output logic converting,
	output logic calibrated
);
	logic strobeLevel;
	logic strobeRise;
	logic strobeFall;
	logic sclkRise;
	logic sclkFall;
	logic [SAMPLE_W-1:0] inputMeta;
	logic [SAMPLE_W-1:0] inputSync;
	sacs_phase_t phase;
	logic [CNT_W-1:0] count;
	logic convDone;
	logic [N_BITS-1:0] result;
	logic resultReady;
	logic [N_BITS-1:0] shiftReg;
	logic [CNT_W-1:0] bitsLeft;
	logic driving;

	sacs_edge_sync strobeSync
	(
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.asyncIn(conversion_start_strobe),
		.level(strobeLevel),
		.rise(strobeRise),
		.fall(strobeFall)
	);

	sacs_edge_sync clockSync
	(
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.asyncIn(serialClock),
		.level(),
		.rise(sclkRise),
		.fall(sclkFall)
	);

	// Analog input stand-in, two flops
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			inputMeta <= '0;
			inputSync <= '0;
		end
		else
		begin
			inputMeta <= inputLsb;
			inputSync <= inputMeta;
		end
	end

	assign convDone = (phase == SACS_CONVERT)
		&& (count == CNT_W'(CONV_LEN - 1));

	// Phase sequencing
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			phase <= SACS_CALIBRATE;
			count <= '0;
		end
		else
		begin
			unique case (phase)
				SACS_CALIBRATE:
				begin
					if (count == CNT_W'(CAL_LEN - 1))
					begin
						phase <= SACS_ACQUIRE;
						count <= '0;
					end
					else
						count <= count + CNT_W'(1);
				end
				SACS_ACQUIRE:
				begin
					if (strobeRise)
					begin
						phase <= SACS_CONVERT;
						count <= '0;
					end
				end
				SACS_CONVERT:
				begin
					if (convDone)
					begin
						phase <= SACS_ACQUIRE;
						count <= '0;
					end
					else
						count <= count + CNT_W'(1);
				end
				default:
				begin
					phase <= SACS_CALIBRATE;
					count <= '0;
				end
			endcase
		end
	end

	// Sample frozen at conversion start, coded at done
	logic [SAMPLE_W-1:0] held;
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			held <= '0;
			result <= '0;
			resultReady <= 1'b0;
		end
		else
		begin
			if (phase == SACS_ACQUIRE && strobeRise)
				held <= inputSync;
			if (convDone)
			begin
				result <= N_BITS'(sacs_saturate(held,
					N_BITS));
				resultReady <= 1'b1;
			end
			else if (driving)
				resultReady <= 1'b0;
		end
	end

	// Serial output, updated on falling serial clock
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			driving <= 1'b0;
			shiftReg <= '0;
			bitsLeft <= '0;
			serialData <= 1'b0;
		end
		else if (strobeRise)
		begin
			driving <= 1'b0;
			serialData <= 1'b0;
		end
		else if (resultReady && !strobeLevel && phase == SACS_ACQUIRE
			&& !driving)
		begin
			driving <= 1'b1;
			serialData <= result[N_BITS-1];
			shiftReg <= result << 1;
			bitsLeft <= CNT_W'(N_BITS);
		end
		else if (driving && sclkFall)
		begin
			// Every fall moves on one bit; the last fall floats the line
			if (bitsLeft == CNT_W'(1))
				driving <= 1'b0;
			else
			begin
				serialData <= shiftReg[N_BITS-1];
				shiftReg <= shiftReg << 1;
			end
			bitsLeft <= bitsLeft - CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			serialData_oe_n <= 1'b1;
			tracking <= 1'b0;
			converting <= 1'b0;
			calibrated <= 1'b0;
		end
		else
		begin
			serialData_oe_n <= ~(driving && !strobeRise);
			tracking <= ((phase == SACS_ACQUIRE) && !strobeRise)
				|| convDone;
			// Level spans exactly the conversion phase
			converting <= ((phase == SACS_ACQUIRE) && strobeRise)
				|| ((phase == SACS_CONVERT) && !convDone);
			if (phase != SACS_CALIBRATE)
				calibrated <= 1'b1;
		end
	end

	a_conv_length: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		$rose(phase == SACS_CONVERT) |-> (phase == SACS_CONVERT) [*8])
		else $error("Conversion ended early");
	a_rise_starts: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		(phase == SACS_ACQUIRE && strobeRise) |=> phase == SACS_CONVERT)
		else $error("Strobe rise did not start conversion");
	a_float_convert: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		(phase == SACS_CONVERT) |-> !driving)
		else $error("Output driven during conversion");
	a_drive_strobe: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		$rose(driving) |-> !strobeLevel)
		else $error("Output driven while strobe high");
	a_sat_code: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		convDone
		&& $signed(held) > $signed(SAMPLE_W'((1 << (N_BITS-1)) - 1))
		|=> result == {1'b0, {(N_BITS-1){1'b1}}})
		else $error("Positive saturation wrong");
	a_msb_first: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		$rose(driving) |-> serialData == result[N_BITS-1])
		else $error("First bit not the sign");
	a_cal_done: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		$rose(phase == SACS_ACQUIRE) && !calibrated
		|-> $past(count) == CNT_W'(CAL_LEN - 1))
		else $error("Calibration length wrong");
	a_track_shift: assert property (
		@(posedge ref_clk) disable iff (!reset_n)
		driving && phase == SACS_ACQUIRE && !strobeRise |=> tracking)
		else $error("Not tracking during shift-out");
	c_conversion: cover property (@(posedge ref_clk) convDone);
	c_shift_out: cover property (@(posedge ref_clk) $fell(driving));
	c_abort: cover property (@(posedge ref_clk) driving && strobeRise);
endmodule

// ==== verification/sacs_host_model.sv ====
module sacs_host_model
	import sacs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic serialData,
	input wire logic serialData_oe_n,
	input wire logic converting,
	input wire logic tracking,
	output logic conversion_start_strobe,
	output logic serialClock
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		conversion_start_strobe = 1'b0;
		serialClock = 1'b0;
	end

	// Serial clock stays low all through the conversion
	task automatic start_conv(input bit glitch, output int len, output bit ok);
		int t;
		len = 0;
		ok = 1'b1;
		conversion_start_strobe <= 1'b1;
		for (t = 0; t < 10 && converting !== 1'b1; t++)
			@(posedge ref_clk);
		while (converting === 1'b1 && len < 100)
		begin
			ok &= serialData_oe_n === 1'b1;
			if (glitch && len == 2)
				conversion_start_strobe <= 1'b0;
			if (glitch && len == 4)
				conversion_start_strobe <= 1'b1;
			len++;
			@(posedge ref_clk);
		end
		repeat (2)
		begin
			@(posedge ref_clk);
			ok &= serialData_oe_n === 1'b1;
		end
		conversion_start_strobe <= 1'b0;
	endtask

	// Mode 0 read, sampled on rises; short reads end by a strobe rise
	task automatic read_word(input int bits, output logic [RESOLUTION-1:0] w,
		output bit ok);
		int t;
		w = '0;
		for (t = 0; t < 20 && serialData_oe_n !== 1'b0; t++)
			@(posedge ref_clk);
		ok = serialData_oe_n === 1'b0;
		for (int i = 0; i < bits; i++)
		begin
			repeat (10) @(posedge ref_clk);
			serialClock <= 1'b1;
			// A floating line reads as the inverse of the last bit
			w[RESOLUTION-1-i] = (serialData_oe_n === 1'b0)
				? serialData : ~serialData;
			ok &= tracking === 1'b1;
			repeat (10) @(posedge ref_clk);
			serialClock <= 1'b0;
		end
		repeat (3) @(posedge ref_clk);
		if (bits < RESOLUTION)
			conversion_start_strobe <= 1'b1;
		for (t = 0; t < 6 && serialData_oe_n !== 1'b1; t++)
			@(posedge ref_clk);
		ok &= serialData_oe_n === 1'b1;
	endtask
endmodule

// ==== verification/sacs_sequencer_tb.sv ====
module sacs_sequencer_tb
	import sacs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CAL_T = 8;
	localparam int CONV_T = 8;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic signed [SAMPLE_W-1:0] inputLsb = '0;
	logic strobe;
	logic sclk;
	logic serialData;
	logic serialData_oe_n;
	logic tracking;
	logic converting;
	logic calibrated;
	int failures = 0;
	int n_compared = 0;
	int vals[7] = '{0, 1, -1, 8191, -8192, 9000, -9000};

	always #2 ref_clk = ~ref_clk;

	sacs_sequencer #(.CAL_LEN(CAL_T), .CONV_LEN(CONV_T)) i_sacs_sequencer
	(
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.conversion_start_strobe(strobe),
		.serialClock(sclk),
		.inputLsb(inputLsb),
		.serialData(serialData),
		.serialData_oe_n(serialData_oe_n),
		.tracking(tracking),
		.converting(converting),
		.calibrated(calibrated)
	);

	sacs_host_model i_sacs_host_model
	(
		.ref_clk(ref_clk),
		.serialData(serialData),
		.serialData_oe_n(serialData_oe_n),
		.converting(converting),
		.tracking(tracking),
		.conversion_start_strobe(strobe),
		.serialClock(sclk)
	);

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Saturated two's complement code, zero extended
	function automatic logic [15:0] code(input int v);
		int hi;
		hi = 2 ** (RESOLUTION - 1) - 1;
		code = 16'(v > hi ? hi : v < -hi - 1 ? -hi - 1 : v);
		code = code & ((16'h0001 << RESOLUTION) - 16'h0001);
	endfunction

	// Input changes after the strobe so a late sample shows up
	task automatic sample(input int v, input bit glitch);
		int len;
		bit ok;
		logic [RESOLUTION-1:0] w;
		inputLsb <= SAMPLE_W'(v);
		repeat (4) @(posedge ref_clk);
		fork
			begin
				repeat (5) @(posedge ref_clk);
				inputLsb <= ~SAMPLE_W'(v);
			end
		join_none
		i_sacs_host_model.start_conv(glitch, len, ok);
		check(16'(len), 16'(CONV_T));
		check(16'(ok), 16'h0001);
		i_sacs_host_model.read_word(RESOLUTION, w, ok);
		check(16'(w), code(v));
		check(16'(ok), 16'h0001);
	endtask

	// Strobe rise in mid read floats the output and takes a new sample
	task automatic abort_read();
		int len;
		bit ok;
		logic [RESOLUTION-1:0] w;
		inputLsb <= SAMPLE_W'(-5);
		repeat (4) @(posedge ref_clk);
		i_sacs_host_model.start_conv(1'b0, len, ok);
		inputLsb <= SAMPLE_W'(291);
		i_sacs_host_model.read_word(5, w, ok);
		check(16'(ok), 16'h0001);
		check(16'(w[RESOLUTION-1 -: 5]), code(-5) >> (RESOLUTION - 5));
		i_sacs_host_model.start_conv(1'b0, len, ok);
		i_sacs_host_model.read_word(RESOLUTION, w, ok);
		check(16'(w), code(291));
	endtask

	initial
	begin
		int t;
		repeat (8) @(posedge ref_clk);
		check({13'h0, serialData_oe_n, tracking, calibrated}, 16'h0004);
		reset_n <= 1'b1;
		for (t = 0; t < 100 && tracking !== 1'b1; t++)
			@(posedge ref_clk);
		check(16'(t >= CAL_T && calibrated === 1'b1), 16'h0001);
		foreach (vals[i])
			sample(vals[i], 1'b0);
		sample(1234, 1'b1);
		abort_read();
		complete_run();
	end

	initial
	begin
		#100000;
		failures++;
		complete_run();
	end
endmodule
